// File: serial_pkg.sv
// Purpose: shared constants and types for the four-mode serial port
// Assumes: MCLK is the oscillator clock (200 MHz, 5 ns period)
// Notes:   register byte address is four times the register index
//
// Functional notes
// - two mode bits pick shift mode, 8-bit UART, 9-bit fixed, 9-bit variable.
// - mode 0 moves 8 bits LSB first on RXD, shift clock on TXD at osc/12.
// - mode 1 frame is start 0, eight data bits LSB first, stop 1.
// - mode 1 reception without filter puts received stop bit in rx_ninth_bit.
// - modes 2 and 3 send start, 8 data, tx_ninth_bit, stop; only baud differs.
// - modes 2 and 3 store ninth received bit, stop bit value ignored.
// - mode 2 bit rate is osc/64, or osc/32 when baud_double is set.
// - writing the serial buffer loads the transmitter and starts sending.
// - reading the serial buffer returns the separate receive register.
// - mode 0 receives when enabled and rx_done clear; else on start bit.
// - transmit and receive run together; a new frame is dropped while rx_done is set.
// - modes 1 and 3 use a baud tick at sixteen times the bit rate.
// - tx_done set after eighth bit in mode 0, at stop start otherwise.
// - rx_done set after eighth bit in mode 0, during stop otherwise.
// - both done flags form the interrupt request and stay readable.
// - modes 2 and 3 with filter set: no rx_done when ninth bit is 0.
// - mode 1 with filter set: no rx_done unless stop bit is 1.
// - the filter bit does nothing in mode 0.
// - receiver enable is software only; while clear no reception starts.
// - internal_baud_select gives modes 1 and 3 osc times 2^double / 2500.
// - otherwise modes 1 and 3 run at timer 1 overflows times 2^double / 32.
// - baud_double doubles modes 1 to 3 and leaves mode 0 alone.
// - async receiver samples states 7, 8, 9 of 16 and takes the majority.
// - a start bit not read as 0 rearms the receiver for a new edge.
// - final shift loads buffer only if rx_done clear and filter passes.
// - mode 0 shift clock low in states 3 to 5, high otherwise and idle.

package serial_pkg;

  // ****************************************************************
  // bus and register map
  // ****************************************************************
  localparam int          ADDR_W    = 12;
  localparam logic [9:0]  IDX_SCTRL = 10'h098;  // serial_control_reg
  localparam logic [9:0]  IDX_SERIAL_BUFFER  = 10'h099;  // serial_buffer_reg
  localparam logic [9:0]  IDX_PWR   = 10'h087;  // power_control_reg
  localparam logic [9:0]  IDX_CONV  = 10'h0d8;  // converter_control_reg
  localparam int          BAUD_DOUBLE_BIT  = 7;
  localparam int          INT_BAUD_SEL_BIT = 7;
  localparam logic [7:0]  SCTRL_RESET = 8'h00;
  localparam logic [7:0]  SERIAL_BUFFER_RESET  = 8'h00;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int          OSC_PERIOD_NS = 5;
  localparam logic [3:0]  MC_LAST       = 4'hb;  // 12 clocks per machine cycle
  localparam logic [3:0]  SCLK_LOW_FIRST = 4'h4; // start of state 3
  localparam logic [3:0]  SCLK_LOW_LAST  = 4'h9; // end of state 5
  localparam logic [3:0]  M0_SAMPLE     = 4'h9;  // state 5 phase 2
  localparam logic [1:0]  FIX_SLOW_LAST = 2'h3;  // osc/4 tick = osc/64 bit
  localparam logic [11:0] GEN_DIVISOR   = 12'h9c4; // 2500
  localparam logic [11:0] GEN_STEP      = 12'h010; // 16 ticks per bit
  localparam logic [11:0] GEN_STEP_X2   = 12'h020;
  localparam logic [3:0]  DIV16_LAST    = 4'hf;
  localparam logic [3:0]  SAMPLE_A      = 4'h6;  // seventh state
  localparam logic [3:0]  SAMPLE_B      = 4'h7;  // eighth state
  localparam logic [3:0]  SAMPLE_C      = 4'h8;  // ninth state
  localparam logic [3:0]  BITS_M0       = 4'h8;
  localparam logic [3:0]  BITS_M1       = 4'ha;
  localparam logic [3:0]  BITS_M23      = 4'hb;
  localparam logic [3:0]  RX_FINAL_M1   = 4'h9;
  localparam logic [3:0]  RX_FINAL_M23  = 4'ha;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {MODE_SHIFT, MODE_UART8, MODE_UART9_FIX, MODE_UART9_VAR} mode_e;
  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_RUN} tx_state_e;
  typedef enum logic [1:0] {RX_IDLE, RX_ASYNC, RX_SYNC} rx_state_e;

  typedef struct packed {
    logic mode_select_high;
    logic mode_select_low;
    logic multiproc_filter_enable;
    logic rx_enable;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic tx_done_flag;
    logic rx_done_flag;
  } serial_control_s;

endpackage : serial_pkg

// File: four_mode_serial_port.sv
// Purpose: four-mode full-duplex serial port with AXI4-Lite registers
// Assumes: RXD_IN and TIMER1_OVF are synchronous to MCLK
// Notes:   TIMER1_OVF is a one-cycle overflow pulse from an outside timer
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps

module four_mode_serial_port
  import serial_pkg::*;
(
  input  wire logic              MCLK,
  input  wire logic              RESET,
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  input  wire logic              TIMER1_OVF,
  input  wire logic              RXD_IN,
  output logic                   RXD_OUT,
  output logic                   RXD_OE,
  output logic                   TXD,
  output logic                   SERIAL_IRQ
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  serial_control_s   sctrl_reg, sctrl_next;
  logic [7:0]        rx_buf_reg;
  logic              baud_double_reg, int_baud_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [7:0]        w_data_reg;
  logic              w_strb_reg, aw_got_reg, w_got_reg;
  logic              awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0]        bresp_reg, rresp_reg;
  logic [31:0]       rdata_reg;
  logic [11:0]       gen_acc_reg;
  logic              t1_half_reg;
  logic [1:0]        fix_cnt_reg;
  logic [3:0]        mc_cnt_reg;
  tx_state_e         tx_state_reg;
  logic [10:0]       tx_shift_reg;
  logic [3:0]        tx_cnt_reg, tx_div_reg;
  rx_state_e         rx_state_reg;
  logic [8:0]        rx_shift_reg;
  logic [3:0]        rx_cnt_reg, rx_div_reg;
  logic              rx_prev_reg, samp_a_reg, samp_b_reg, m0_samp_reg;
  logic              txd_reg, rxd_out_reg, rxd_oe_reg, irq_reg;

  // ****************************************************************
  // register bus decode
  // ****************************************************************
  // write takes effect once address and data are both held
  wire       wr_go     = aw_got_reg && w_got_reg && !bvalid_reg;
  wire [9:0] wr_idx    = aw_addr_reg[ADDR_W-1:2];
  wire       wr_en     = wr_go && w_strb_reg;
  wire       sctrl_wr  = wr_en && (wr_idx == IDX_SCTRL);
  wire       serial_buffer_wr   = wr_en && (wr_idx == IDX_SERIAL_BUFFER);
  wire       pwr_wr    = wr_en && (wr_idx == IDX_PWR);
  wire       conv_wr   = wr_en && (wr_idx == IDX_CONV);
  wire       wr_hit    = (wr_idx == IDX_SCTRL) || (wr_idx == IDX_SERIAL_BUFFER) ||
                         (wr_idx == IDX_PWR) || (wr_idx == IDX_CONV);
  wire [9:0] rd_idx    = S_AXI_ARADDR[ADDR_W-1:2];
  wire       rd_hit    = (rd_idx == IDX_SCTRL) || (rd_idx == IDX_SERIAL_BUFFER) ||
                         (rd_idx == IDX_PWR) || (rd_idx == IDX_CONV);
  // receive register, not the transmitter, answers the buffer address
  wire [7:0] rd_byte   = (rd_idx == IDX_SCTRL) ? sctrl_reg :
                         (rd_idx == IDX_SERIAL_BUFFER)  ? rx_buf_reg :
                         (rd_idx == IDX_PWR)   ? {baud_double_reg, 7'h00} :
                         (rd_idx == IDX_CONV)  ? {int_baud_reg, 7'h00} : 8'h00;

  // write channels: address and data accepted in either order
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      aw_addr_reg <= '0;
      w_data_reg  <= 8'h00;
      w_strb_reg  <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && awready_reg) begin
        aw_addr_reg <= S_AXI_AWADDR;
        aw_got_reg  <= 1'b1;
        awready_reg <= 1'b0;
      end
      if (S_AXI_WVALID && wready_reg) begin
        w_data_reg <= S_AXI_WDATA[7:0];
        w_strb_reg <= S_AXI_WSTRB[0];
        w_got_reg  <= 1'b1;
        wready_reg <= 1'b0;
      end
      if (wr_go) begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && S_AXI_BREADY) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // read channel: one read at a time, data registered with the answer
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_OKAY;
    end else if (S_AXI_ARVALID && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= {24'h00_0000, rd_byte};
      rresp_reg   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // baud tick generation
  // ****************************************************************
  wire mode_e   mode      = mode_e'({sctrl_reg.mode_select_high, sctrl_reg.mode_select_low});
  wire          is_m0     = (mode == MODE_SHIFT);
  wire [11:0]   gen_sum   = gen_acc_reg + (baud_double_reg ? GEN_STEP_X2 : GEN_STEP);
  wire          gen_tick  = (gen_sum >= GEN_DIVISOR);
  wire          t1_tick   = TIMER1_OVF && (baud_double_reg || t1_half_reg);
  wire          fix_tick  = baud_double_reg ? fix_cnt_reg[0] :
                            (fix_cnt_reg == FIX_SLOW_LAST);
  // sixteen ticks per bit in every asynchronous mode
  wire          tick16    = (mode == MODE_UART9_FIX) ? fix_tick :
                            (int_baud_reg ? gen_tick : t1_tick);
  wire          mc_end    = (mc_cnt_reg == MC_LAST);
  wire          sclk_low  = (mc_cnt_reg >= SCLK_LOW_FIRST) && (mc_cnt_reg <= SCLK_LOW_LAST);

  // dividers: fractional 2500 divider, timer halving, fixed rate, machine cycle
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      gen_acc_reg <= 12'h000;
      t1_half_reg <= 1'b0;
      fix_cnt_reg <= 2'h0;
      mc_cnt_reg  <= 4'h0;
    end else begin
      gen_acc_reg <= gen_tick ? gen_sum - GEN_DIVISOR : gen_sum;
      if (TIMER1_OVF) t1_half_reg <= !t1_half_reg;
      fix_cnt_reg <= fix_cnt_reg + 2'h1;
      mc_cnt_reg  <= mc_end ? 4'h0 : mc_cnt_reg + 4'h1;
    end
  end

  // ****************************************************************
  // transmitter
  // ****************************************************************
  wire       tx_roll   = tick16 && (tx_div_reg == DIV16_LAST);
  wire       tx_step   = (tx_state_reg == TX_RUN) && (is_m0 ? mc_end : tx_roll);
  wire       tx_last   = (tx_cnt_reg == 4'h1);
  wire       ti_set    = tx_step && (is_m0 ? tx_last : (tx_cnt_reg == 4'h2));
  wire       ninth_tx  = (mode == MODE_UART8) ? 1'b1 : sctrl_reg.tx_ninth_bit;
  wire [3:0] tx_bits   = is_m0 ? BITS_M0 : ((mode == MODE_UART8) ? BITS_M1 : BITS_M23);
  wire       tx_go     = (tx_state_reg == TX_WAIT) && (is_m0 ? mc_end : tx_roll);

  // frame load on buffer write, then one bit per step, ones shifted in
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      tx_state_reg <= TX_IDLE;
      tx_shift_reg <= 11'h7ff;
      tx_cnt_reg   <= 4'h0;
      tx_div_reg   <= 4'h0;
    end else begin
      if (tick16) tx_div_reg <= tx_div_reg + 4'h1;
      if (serial_buffer_wr) begin
        tx_state_reg <= TX_WAIT;
        tx_cnt_reg   <= tx_bits;
        tx_shift_reg <= is_m0 ? {3'h0, w_data_reg}
                              : {1'b1, ninth_tx, w_data_reg, 1'b0};
      end else if (tx_go) begin
        tx_state_reg <= TX_RUN;
      end else if (tx_step) begin
        tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
        tx_cnt_reg   <= tx_cnt_reg - 4'h1;
        if (tx_last) tx_state_reg <= TX_IDLE;
      end
    end
  end

  // ****************************************************************
  // receiver
  // ****************************************************************
  wire       rx_maj    = (samp_a_reg & samp_b_reg) | (samp_a_reg & RXD_IN) |
                         (samp_b_reg & RXD_IN);
  wire       rx_evt    = tick16 && (rx_state_reg == RX_ASYNC) && (rx_div_reg == SAMPLE_C);
  wire [3:0] rx_final  = (mode == MODE_UART8) ? RX_FINAL_M1 : RX_FINAL_M23;
  wire       start_bad = rx_evt && (rx_cnt_reg == 4'h0) && rx_maj;
  wire       async_fin = rx_evt && (rx_cnt_reg == rx_final);
  wire       sync_fin  = (rx_state_reg == RX_SYNC) && mc_end && (rx_cnt_reg == 4'h1);
  wire       async_go  = tick16 && sctrl_reg.rx_enable && rx_prev_reg && !RXD_IN &&
                         !is_m0 && (rx_state_reg == RX_IDLE);
  wire       sync_go   = is_m0 && mc_end && sctrl_reg.rx_enable &&
                         !sctrl_reg.rx_done_flag && (rx_state_reg == RX_IDLE);
  // filter never applies in mode 0
  wire       rx_pass   = is_m0 || !sctrl_reg.multiproc_filter_enable ||
                         ((mode == MODE_UART8) ? rx_maj : rx_shift_reg[8]);
  wire       rx_load   = (async_fin || sync_fin) && !sctrl_reg.rx_done_flag && rx_pass;
  wire [7:0] rx_data   = sync_fin ? {m0_samp_reg, rx_shift_reg[8:2]} :
                         ((mode == MODE_UART8) ? rx_shift_reg[8:1] : rx_shift_reg[7:0]);
  wire       rx_ninth  = (mode == MODE_UART8) ? rx_maj : rx_shift_reg[8];

  // bit sampling, shifting and frame end for both receive styles
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      rx_state_reg <= RX_IDLE;
      rx_shift_reg <= 9'h1ff;
      rx_cnt_reg   <= 4'h0;
      rx_div_reg   <= 4'h0;
      rx_prev_reg  <= 1'b1;
      samp_a_reg   <= 1'b1;
      samp_b_reg   <= 1'b1;
      m0_samp_reg  <= 1'b1;
    end else begin
      if (tick16) rx_prev_reg <= RXD_IN;
      if (tick16) rx_div_reg <= async_go ? 4'h0 : rx_div_reg + 4'h1;
      if (tick16 && rx_div_reg == SAMPLE_A) samp_a_reg <= RXD_IN;
      if (tick16 && rx_div_reg == SAMPLE_B) samp_b_reg <= RXD_IN;
      if (mc_cnt_reg == M0_SAMPLE) m0_samp_reg <= RXD_IN;
      if (async_go) begin
        rx_state_reg <= RX_ASYNC;
        rx_cnt_reg   <= 4'h0;
      end else if (sync_go) begin
        rx_state_reg <= RX_SYNC;
        rx_cnt_reg   <= BITS_M0;
      end else if (start_bad || async_fin || sync_fin) begin
        rx_state_reg <= RX_IDLE;
      end else if (rx_evt) begin
        if (rx_cnt_reg != 4'h0) rx_shift_reg <= {rx_maj, rx_shift_reg[8:1]};
        rx_cnt_reg <= rx_cnt_reg + 4'h1;
      end else if (rx_state_reg == RX_SYNC && mc_end) begin
        rx_shift_reg <= {m0_samp_reg, rx_shift_reg[8:1]};
        rx_cnt_reg   <= rx_cnt_reg - 4'h1;
      end
    end
  end

  // ****************************************************************
  // control register and receive buffer
  // ****************************************************************
  // hardware sets are applied after the software write so they win
  always_comb begin
    sctrl_next = sctrl_reg;
    if (sctrl_wr) sctrl_next = serial_control_s'(w_data_reg);
    if (ti_set) sctrl_next.tx_done_flag = 1'b1;
    if (rx_load) begin
      sctrl_next.rx_done_flag = 1'b1;
      if (!is_m0) sctrl_next.rx_ninth_bit = rx_ninth;
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      sctrl_reg       <= serial_control_s'(SCTRL_RESET);
      rx_buf_reg      <= SERIAL_BUFFER_RESET;
      baud_double_reg <= 1'b0;
      int_baud_reg    <= 1'b0;
    end else begin
      sctrl_reg <= sctrl_next;
      if (rx_load) rx_buf_reg <= rx_data;
      if (pwr_wr) baud_double_reg <= w_data_reg[BAUD_DOUBLE_BIT];
      if (conv_wr) int_baud_reg <= w_data_reg[INT_BAUD_SEL_BIT];
    end
  end

  // ****************************************************************
  // pin and output registers
  // ****************************************************************
  wire tx_run    = (tx_state_reg == TX_RUN);
  wire m0_active = tx_run || (rx_state_reg == RX_SYNC);
  wire txd_next  = is_m0 ? !(m0_active && sclk_low)
                         : (tx_run ? tx_shift_reg[0] : 1'b1);
  wire irq_next  = sctrl_next.tx_done_flag || sctrl_next.rx_done_flag;

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      txd_reg     <= 1'b1;
      rxd_out_reg <= 1'b1;
      rxd_oe_reg  <= 1'b0;
      irq_reg     <= 1'b0;
    end else begin
      txd_reg     <= txd_next;
      rxd_out_reg <= tx_shift_reg[0];
      rxd_oe_reg  <= is_m0 && tx_run;
      irq_reg     <= irq_next;
    end
  end

  assign S_AXI_AWREADY = awready_reg;
  assign S_AXI_WREADY  = wready_reg;
  assign S_AXI_BVALID  = bvalid_reg;
  assign S_AXI_BRESP   = bresp_reg;
  assign S_AXI_ARREADY = arready_reg;
  assign S_AXI_RVALID  = rvalid_reg;
  assign S_AXI_RDATA   = rdata_reg;
  assign S_AXI_RRESP   = rresp_reg;
  assign TXD           = txd_reg;
  assign RXD_OUT       = rxd_out_reg;
  assign RXD_OE        = rxd_oe_reg;
  assign SERIAL_IRQ    = irq_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  property p_mode2_slow;
    disable iff (RESET || sctrl_wr || pwr_wr)  // a rate or mode write ends the window
    (mode == MODE_UART9_FIX) && !baud_double_reg && tick16 && !sctrl_wr && !pwr_wr
      |=> !tick16 [*3] ##1 tick16;
  endproperty
  a_mode2_slow: assert property (p_mode2_slow) else $error("mode 2 tick spacing wrong");

  property p_sclk_low;
    is_m0 && m0_active && (mc_cnt_reg == 4'h5) |=> !TXD;
  endproperty
  a_sclk_low: assert property (p_sclk_low) else $error("shift clock not low");

  property p_ti_set;
    ti_set |=> sctrl_reg.tx_done_flag ##1 SERIAL_IRQ;
  endproperty
  a_ti_set: assert property (p_ti_set) else $error("tx done not raised");

  property p_filter9;
    rx_load && !is_m0 && (mode != MODE_UART8) && sctrl_reg.multiproc_filter_enable
      |=> sctrl_reg.rx_ninth_bit;
  endproperty
  a_filter9: assert property (p_filter9) else $error("filtered frame accepted");

  property p_load_once;
    rx_load |-> !sctrl_reg.rx_done_flag ##1 (rx_buf_reg == $past(rx_data));
  endproperty
  a_load_once: assert property (p_load_once) else $error("buffer load wrong");

  property p_start_reject;
    start_bad |=> (rx_state_reg == RX_IDLE) && (rx_buf_reg == $past(rx_buf_reg));
  endproperty
  a_start_reject: assert property (p_start_reject) else $error("bad start kept");

  property p_ren_block;
    !sctrl_reg.rx_enable && (rx_state_reg == RX_IDLE) && !sctrl_wr |=> rx_state_reg == RX_IDLE;
  endproperty
  a_ren_block: assert property (p_ren_block) else $error("reception while disabled");

  property p_write_starts;
    serial_buffer_wr |=> (tx_state_reg == TX_WAIT) && (tx_cnt_reg != 4'h0);
  endproperty
  a_write_starts: assert property (p_write_starts) else $error("write did not start tx");

  property p_idle_high;
    (tx_state_reg == TX_IDLE) && (rx_state_reg != RX_SYNC) |=> TXD;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("idle transmit line low");

endmodule : four_mode_serial_port

// File: serial_peer.sv
// Purpose: remote async uart partner on TXD and the RXD line
// Assumes: caller starts each task just after a rising MCLK edge
// Notes:   line idles high, as with the pin pull-up
`timescale 1ns/1ps
module serial_peer (
  input  wire logic clk,
  input  wire logic txd,
  output logic      line
);
  initial line = 1'b1;
  // drives one frame, lsb first, then idles high
  task automatic send(input logic [10:0] f, input int nb, input int bl);
    for (int i = 0; i < nb; i++) begin
      line <= f[i];
      repeat (bl) @(posedge clk);
    end
    line <= 1'b1;
  endtask : send
  // waits for a start edge, samples each bit at its centre
  task automatic catch(input int nb, input int bl, output logic [10:0] f);
    int n;
    n = 0;
    f = 'x;
    while (txd !== 1'b0 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    repeat (bl / 2) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      f[i] = txd;
      repeat (bl) @(posedge clk);
    end
  endtask : catch
  // mode 0 partner: puts the next bit on the line at each falling shift clock
  task automatic shift0(input logic [7:0] v);
    int i, n;
    logic p;
    i = 0;
    p = 1'b1;
    for (n = 0; n < 2000 && i < 8; n++) begin
      @(posedge clk);
      if (!txd && p) begin
        line <= v[i];
        i++;
      end
      p = txd;
    end
    repeat (12) @(posedge clk);
    line <= 1'b1;
  endtask : shift0
endmodule : serial_peer

// File: tb.sv
// Purpose: self-checking bench for the serial port
// Assumes: mode 2 bit time 64 clocks, generator doubled 1250 clocks
// Notes:   random bytes from an lfsr seeded with 3533
`timescale 1ns/1ps
module tb;
  import serial_pkg::*;
  logic mclk, rst, awv, wv, bre, arv, rre, awr, wrd, bv, arr, rv, rxo, rxoe, txd, irq, pl, ovf;
  logic [ADDR_W-1:0] awa, ara;
  logic [31:0]       wd, rdat, rq;
  logic [1:0]        bres, rres, rs, oc;
  logic [15:0]       seed;
  logic [7:0]        d;
  logic [10:0]       f;
  int                err_total, num_checks;
  localparam logic [ADDR_W-1:0] SC = {IDX_SCTRL, 2'b00};
  localparam logic [ADDR_W-1:0] SB = {IDX_SERIAL_BUFFER, 2'b00};
  wire rxd = rxoe ? rxo : pl;
  four_mode_serial_port dut (.MCLK(mclk), .RESET(rst), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'h1),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(bres), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdat), .S_AXI_RRESP(rres), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre),
    .TIMER1_OVF(ovf), .RXD_IN(rxd), .RXD_OUT(rxo), .RXD_OE(rxoe), .TXD(txd),
    .SERIAL_IRQ(irq));
  serial_peer peer (.clk(mclk), .txd(txd), .line(pl));
  task give_verdict();
    if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      err_total++;
    end
  endtask : chk
  function automatic logic [7:0] nxt();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction : nxt
  function automatic logic [10:0] fr(input logic n9, input logic [7:0] v);
    return {1'b1, n9, v, 1'b0};
  endfunction : fr
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
    int n;
    n = 0;
    awa <= a;
    wd <= {24'h0, v};
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    while ((awv || wv || bv !== 1'b1) && n < 200) begin
      @(posedge mclk);
      n++;
      if (awr === 1'b1) awv <= 1'b0;
      if (wrd === 1'b1) wv <= 1'b0;
    end
    bre <= 1'b0;
    @(posedge mclk);
    if (n >= 200) begin
      err_total++;
      give_verdict();
    end
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] q, output logic [1:0] r);
    int n;
    n = 0;
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    while ((arv || rv !== 1'b1) && n < 200) begin
      @(posedge mclk);
      n++;
      if (arr === 1'b1) arv <= 1'b0;
    end
    q = rdat;
    r = rres;
    rre <= 1'b0;
    @(posedge mclk);
    if (n >= 200) begin
      err_total++;
      give_verdict();
    end
  endtask : rd
  // mode 0 capture: data pin read at each rising shift clock
  task automatic m0cap(output logic [7:0] v);
    int i, n;
    logic p;
    i = 0;
    p = 1'b1;
    v = 8'h00;
    for (n = 0; n < 2000 && i < 8; n++) begin
      @(posedge mclk);
      if (txd && !p) begin
        v[i] = rxd;
        i++;
      end
      p = txd;
    end
    if (i < 8) begin
      err_total++;
      give_verdict();
    end
  endtask : m0cap
  // timer 1 stand-in: an overflow pulse every four clocks
  always @(posedge mclk) begin
    oc <= oc + 2'h1;
    ovf <= (oc == 2'h3);
  end
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // main sequence: reset, map, mode 2 both ways with filter, mode 1 generator
  initial begin
    {rst, awv, wv, bre, arv, rre} = 6'h20;
    {awa, ara, wd} = '0;
    seed = 16'h0dcd;
    {oc, ovf} = 3'h0;
    err_total = 0;
    num_checks = 0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(SC, rq, rs);
    chk(rq, 32'h0);
    chk({31'h0, txd}, 32'h1);
    rd(12'h100, rq, rs);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    for (int k = 0; k < 2; k++) begin
      wr(SC, {4'b1001, k[0], 3'b000});
      d = nxt();
      fork
        peer.catch(11, 64, f);
        wr(SB, d);
      join
      chk({21'h0, f}, {21'h0, fr(k[0], d)});
      rd(SC, rq, rs);
      chk(rq & 32'h2, 32'h2);
      chk({31'h0, irq}, 32'h1);
      d = nxt();
      peer.send(fr(k[0], d), 11, 64);
      rd(SB, rq, rs);
      chk(rq, {24'h0, d});
      rd(SC, rq, rs);
      chk(rq & 32'h5, {29'h0, k[0], 2'b01});
      wr(SC, 8'hb0);
      peer.send(fr(k[0], ~d), 11, 64);
      rd(SB, rq, rs);
      chk(rq, {24'h0, k[0] ? ~d : d});
    end
    wr({IDX_CONV, 2'b00}, 8'h80);
    wr({IDX_PWR, 2'b00}, 8'h80);
    wr(SC, 8'h50);
    d = nxt();
    fork
      peer.catch(10, 1250, f);
      wr(SB, d);
    join
    chk({22'h0, f[9:0]}, {22'h0, 1'b1, d, 1'b0});
    // mode 0 transmit, then mode 0 receive from the partner
    wr(SC, 8'h00);
    d = nxt();
    wr(SB, d);
    m0cap(rq[7:0]);
    chk({24'h0, rq[7:0]}, {24'h0, d});
    d = nxt();
    fork
      peer.shift0(d);
      wr(SC, 8'h10);
    join
    rd(SB, rq, rs);
    chk(rq, {24'h0, d});
    rd(SC, rq, rs);
    chk(rq & 32'h1, 32'h1);
    // mode 3 from timer 1 overflows, doubled
    wr({IDX_CONV, 2'b00}, 8'h00);
    wr(SC, 8'hd8);
    d = nxt();
    fork
      peer.catch(11, 64, f);
      wr(SB, d);
    join
    chk({21'h0, f}, {21'h0, fr(1'b1, d)});
    give_verdict();
  end
endmodule : tb
